// File: design/ppc_defines.vh
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH
`define PPC_DIST_W        9
`define PPC_TREE_N        11
`define PPC_IDX_STATUS_LED_1      8
`define PPC_CLK_HZ        10000000
`define PPC_PULSE_NS      16000000
`define PPC_PULSE_NS_LONG 64000000
`define PPC_PULSE_CYC     ((`PPC_CLK_HZ / 1000) * (`PPC_PULSE_NS / 1000) / 1000)
`define PPC_PULSE_CYC_LONG ((`PPC_CLK_HZ / 1000) * (`PPC_PULSE_NS_LONG / 1000) / 1000)
`define PPC_CNT_W         20
`define PPC_ZERO_CNT      20'h00000
`define PPC_ONE_CNT       20'h00001
`define PPC_STRAP_AGE0    2'h0
`define PPC_STRAP_STEP    2'h1
`define PPC_STRAP_SETTLE  2'h2
`define PPC_ST_NORMAL     3'h0
`define PPC_ST_SAVE       3'h1
`define PPC_ST_ENERGY_DETECT_POWERDOWN       3'h2
`define PPC_ST_PDOWN      3'h3
`define PPC_ST_SLOW       3'h4
`define PPC_ST_TREE       3'h5
`endif

// File: design/ppc_nand_chain.v
`timescale 1ns/1ps
`include "ppc_defines.vh"
module ppc_nand_chain #(
  parameter N = 11
) (
  // Tree inputs, index 0 first in order
  input  wire [N-1:0] tree_in,
  input  wire         skip_status_led_1,
  // Chain result
  output wire         tree_out
);
  wire [N:0] stage;
  wire       odd_len;
  // Odd live length needs one extra inversion so all-high reads high
  assign stage[0] = 1'b1;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_nand
      if (i == `PPC_IDX_STATUS_LED_1) begin : g_opt
        // Partial chain bypasses the missing pin
        assign stage[i+1] = skip_status_led_1 ? stage[i] : ~(stage[i] & tree_in[i]);
      end else begin : g_std
        assign stage[i+1] = ~(stage[i] & tree_in[i]);
      end
    end
  endgenerate
  assign odd_len  = ((N % 2) == 1) ^ skip_status_led_1;
  assign tree_out = stage[N] ^ odd_len;
endmodule // ppc_nand_chain

// File: design/ppc_power_ctrl.v
`timescale 1ns/1ps
`include "ppc_defines.vh"
module ppc_power_ctrl #(
  parameter PULSE_CYC      = `PPC_PULSE_CYC,
  parameter PULSE_CYC_LONG = `PPC_PULSE_CYC_LONG
) (
  // Clock and reset
  input  wire                   clk_sys,
  input  wire                   rst,
  // Control bits from the register file
  input  wire                   power_save_en,
  input  wire                   energy_detect_powerdown_disable,
  input  wire                   pll_off_en,
  input  wire                   power_down,
  input  wire                   slow_osc_en,
  input  wire                   soft_reset,
  input  wire                   tree_sw_en,
  input  wire                   long_pulse_gap,
  input  wire                   mii_variant,
  // Link status from the transceiver
  input  wire                   autoneg_en,
  input  wire                   link_up,
  input  wire [`PPC_DIST_W-1:0] fault_dist_raw,
  // Pins
  input  wire                   tree_strap_pin,
  input  wire                   mdio_pin,
  input  wire                   mdc_pin,
  input  wire                   rxd1_pin,
  input  wire                   rxd0_pin,
  input  wire                   crs_dv_pin,
  input  wire                   ref_clk_pin,
  input  wire                   interrupt_out_pin,
  input  wire                   txen_pin,
  input  wire                   status_led_1_pin,
  input  wire                   status_led_0_pin,
  input  wire                   txd0_pin,
  // Outputs
  output reg                    txd1_out,
  output reg                    tree_active,
  output reg                    pins_input_only,
  output reg  [`PPC_DIST_W-1:0] fault_dist,
  output reg                    rx_blocks_on,
  output reg                    tx_on,
  output reg                    energy_det_on,
  output reg                    pll_on,
  output reg                    use_slow_osc,
  output reg                    crystal_in_en,
  output reg                    mgmt_only,
  output reg                    link_pulse,
  output reg                    low_power_mode,
  output reg  [2:0]             power_state
);
  reg  [`PPC_TREE_N-1:0] sync1;
  reg  [`PPC_TREE_N-1:0] sync2;
  reg                    strap1;
  reg                    strap2;
  reg                    strap_latched;
  reg                    strap_taken;
  reg  [1:0]             strap_age;
  reg  [2:0]             next_state;
  reg  [`PPC_CNT_W-1:0]  pulse_cnt;
  wire [`PPC_CNT_W-1:0]  pulse_reload;
  wire                   idle_link;
  wire                   chain_out;

  // Pins pass two flops; tree order fixed
  wire [`PPC_TREE_N-1:0] pin_vec = {txd0_pin, status_led_0_pin, status_led_1_pin, txen_pin,
                                    interrupt_out_pin, ref_clk_pin, crs_dv_pin, rxd0_pin,
                                    rxd1_pin, mdc_pin, mdio_pin};

  // Pins idle high so the chain starts from all-high after reset
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= {`PPC_TREE_N{1'b1}};
      sync2 <= {`PPC_TREE_N{1'b1}};
    end else begin
      sync1 <= pin_vec;
      sync2 <= sync1;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap1 <= 1'b0;
      strap2 <= 1'b0;
    end else begin
      strap1 <= tree_strap_pin;
      strap2 <= strap1;
    end
  end

  // Strap pair shows reset values for two edges; latching earlier misses it
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_age <= `PPC_STRAP_AGE0;
    end else if (strap_age != `PPC_STRAP_SETTLE) begin
      strap_age <= strap_age + `PPC_STRAP_STEP;
    end
  end

  // Strap is caught once after reset release
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_latched <= 1'b0;
      strap_taken   <= 1'b0;
    end else if (!strap_taken && strap_age == `PPC_STRAP_SETTLE) begin
      strap_latched <= strap2;
      strap_taken   <= 1'b1;
    end
  end

  ppc_nand_chain #(
    .N (`PPC_TREE_N)
  ) u_chain (
    .tree_in   (sync2),
    .skip_status_led_1 (mii_variant),
    .tree_out  (chain_out)
  );

  assign idle_link = autoneg_en & ~link_up;
  // Longer pulse gap trades wake latency for lower power
  assign pulse_reload = long_pulse_gap ? PULSE_CYC_LONG[`PPC_CNT_W-1:0]
                                       : PULSE_CYC[`PPC_CNT_W-1:0];

  always @* begin
    if (strap_latched | tree_sw_en) begin
      next_state = `PPC_ST_TREE;
    end else if (power_down & slow_osc_en) begin
      next_state = `PPC_ST_SLOW;
    end else if (power_down) begin
      next_state = `PPC_ST_PDOWN;
    end else if (!energy_detect_powerdown_disable && idle_link) begin
      next_state = `PPC_ST_ENERGY_DETECT_POWERDOWN;
    end else if (power_save_en && idle_link) begin
      next_state = `PPC_ST_SAVE;
    end else begin
      next_state = `PPC_ST_NORMAL;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_state     <= `PPC_ST_NORMAL;
      rx_blocks_on    <= 1'b1;
      tx_on           <= 1'b1;
      energy_det_on   <= 1'b1;
      pll_on          <= 1'b1;
      use_slow_osc    <= 1'b0;
      crystal_in_en   <= 1'b1;
      mgmt_only       <= 1'b0;
      low_power_mode  <= 1'b0;
      tree_active     <= 1'b0;
      pins_input_only <= 1'b0;
      txd1_out        <= 1'b0;
      fault_dist      <= {`PPC_DIST_W{1'b0}};
    end else begin
      power_state     <= soft_reset ? `PPC_ST_NORMAL : next_state;
      fault_dist      <= fault_dist_raw;
      tree_active     <= (next_state == `PPC_ST_TREE);
      pins_input_only <= (next_state == `PPC_ST_TREE);
      txd1_out        <= (next_state == `PPC_ST_TREE) ? chain_out : 1'b0;
      case (next_state)
        `PPC_ST_SAVE: begin
          rx_blocks_on  <= 1'b0;
          tx_on         <= 1'b1;
          energy_det_on <= 1'b1;
          pll_on        <= 1'b1;
          use_slow_osc  <= 1'b0;
          crystal_in_en <= 1'b1;
          mgmt_only     <= 1'b0;
          low_power_mode <= 1'b1;
        end
        `PPC_ST_ENERGY_DETECT_POWERDOWN: begin
          rx_blocks_on  <= 1'b0;
          tx_on         <= 1'b1;
          energy_det_on <= 1'b1;
          pll_on        <= ~pll_off_en;
          use_slow_osc  <= 1'b0;
          crystal_in_en <= 1'b1;
          mgmt_only     <= 1'b0;
          low_power_mode <= 1'b1;
        end
        `PPC_ST_PDOWN, `PPC_ST_SLOW: begin
          rx_blocks_on  <= 1'b0;
          tx_on         <= 1'b0;
          energy_det_on <= 1'b0;
          pll_on        <= 1'b0;
          use_slow_osc  <= (next_state == `PPC_ST_SLOW);
          crystal_in_en <= (next_state != `PPC_ST_SLOW);
          mgmt_only     <= 1'b1;
          low_power_mode <= 1'b1;
        end
        default: begin
          rx_blocks_on  <= 1'b1;
          tx_on         <= 1'b1;
          energy_det_on <= 1'b1;
          pll_on        <= 1'b1;
          use_slow_osc  <= 1'b0;
          crystal_in_en <= 1'b1;
          mgmt_only     <= 1'b0;
          low_power_mode <= 1'b0;
        end
      endcase
    end
  end

  // Link pulses keep two sleeping partners able to wake
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse_cnt  <= `PPC_ZERO_CNT;
      link_pulse <= 1'b0;
    end else if (power_state != `PPC_ST_ENERGY_DETECT_POWERDOWN) begin
      pulse_cnt  <= `PPC_ZERO_CNT;
      link_pulse <= 1'b0;
    end else if (pulse_cnt == `PPC_ZERO_CNT) begin
      pulse_cnt  <= pulse_reload - `PPC_ONE_CNT;
      link_pulse <= 1'b1;
    end else begin
      pulse_cnt  <= pulse_cnt - `PPC_ONE_CNT;
      link_pulse <= 1'b0;
    end
  end

endmodule // ppc_power_ctrl

// File: sim/ppc_chk.sv
`timescale 1ns/1ps
module ppc_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Control inputs
  input wire logic       autoneg_en,
  input wire logic       link_up,
  input wire logic       energy_detect_powerdown_disable,
  input wire logic       pll_off_en,
  input wire logic       power_down,
  input wire logic [8:0] fault_dist_raw,
  // Outputs
  input wire logic [8:0] fault_dist,
  input wire logic [2:0] power_state,
  input wire logic       rx_blocks_on,
  input wire logic       pll_on,
  input wire logic       mgmt_only,
  input wire logic       use_slow_osc,
  input wire logic       crystal_in_en,
  input wire logic       tree_active,
  input wire logic       pins_input_only,
  input wire logic       link_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_dist_follow: assert property (!$past(rst) |-> fault_dist == $past(fault_dist_raw))
    else $error("distance not one cycle behind raw");
  a_save_gate: assert property (power_state == 3'h1 |-> $past(autoneg_en) && !$past(link_up))
    else $error("power saving without its conditions");
  a_save_blocks: assert property (power_state == 3'h1 |-> !rx_blocks_on && pll_on)
    else $error("power saving block enables wrong");
  a_energy_detect_powerdown_gate: assert property (power_state == 3'h2 |-> !$past(energy_detect_powerdown_disable) && $past(autoneg_en))
    else $error("energy detect sleep without its conditions");
  a_energy_detect_powerdown_pll: assert property (power_state == 3'h2 && $past(pll_off_en) |-> !pll_on)
    else $error("pll left running");
  a_pulse_energy_detect_powerdown: assert property (link_pulse |-> $past(power_state) == 3'h2)
    else $error("link pulse outside energy detect sleep");
  a_pdown_hold: assert property (power_state == 3'h3 |-> $past(power_down) && mgmt_only)
    else $error("power down state wrong");
  a_slow_clk: assert property (power_state == 3'h4 |-> use_slow_osc && !crystal_in_en)
    else $error("slow oscillator selection wrong");
  a_tree_pins: assert property (tree_active |-> pins_input_only)
    else $error("tree pins not input only");
endmodule // ppc_chk
bind ppc_power_ctrl ppc_chk u_chk (.*);

// File: sim/ppc_board.sv
`timescale 1ns/1ps
module ppc_board (
  // Clock
  input wire logic        clk_sys,
  // Tree pins, index 0 first in order
  output reg       [10:0] pins
);
  initial pins = 11'h7FF;
  task all_high; @(posedge clk_sys); pins <= 11'h7FF; endtask
  // Earlier pins stay low, so each drop of a pin still in the chain must flip it
  task drop(input integer i); @(posedge clk_sys); pins[i] <= 1'b0; endtask
endmodule // ppc_board

// File: sim/ppc_power_ctrl_tb_top.sv
`timescale 1ns/1ps
module ppc_power_ctrl_tb_top;
  reg clk_sys, rst, power_save_en, energy_detect_powerdown_disable, pll_off_en, power_down, slow_osc_en;
  reg soft_reset, tree_sw_en, long_pulse_gap, mii_variant, autoneg_en, link_up, tree_strap_pin;
  reg [8:0] fault_dist_raw;
  reg [6:0] v;
  wire [10:0] pins;
  wire txd1_out, tree_active, pins_input_only, rx_blocks_on, tx_on, energy_det_on, pll_on;
  wire use_slow_osc, crystal_in_en, mgmt_only, link_pulse, low_power_mode;
  wire [8:0] fault_dist;
  wire [2:0] power_state;
  integer miscompares = 0, n_checks = 0, i, k, t, g, s;
  ppc_board board (.clk_sys(clk_sys), .pins(pins));
  ppc_power_ctrl #(.PULSE_CYC(20), .PULSE_CYC_LONG(40)) uut (.mdio_pin(pins[0]),
    .mdc_pin(pins[1]), .rxd1_pin(pins[2]), .rxd0_pin(pins[3]), .crs_dv_pin(pins[4]),
    .ref_clk_pin(pins[5]), .interrupt_out_pin(pins[6]), .txen_pin(pins[7]),
    .status_led_1_pin(pins[8]), .status_led_0_pin(pins[9]), .txd0_pin(pins[10]), .*);
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cyc(input integer n); repeat (n) @(posedge clk_sys); #1; endtask
  task set(input [6:0] c);
    @(posedge clk_sys);
    {power_save_en, energy_detect_powerdown_disable, pll_off_en, power_down, slow_osc_en, autoneg_en, link_up} <= c;
  endtask
  task wp(output integer n);
    n = 0;
    do begin cyc(1); n++; end while (link_pulse !== 1'b1 && n < 1000);
    if (n >= 1000) begin miscompares++; close_out; end
  endtask
  // Priority: slow over power down over energy sleep over saving
  function [2:0] mdl(input [6:0] c);
    if (c[3] && c[2]) mdl = 3'h4;
    else if (c[3]) mdl = 3'h3;
    else if (!c[5] && c[1] && !c[0]) mdl = 3'h2;
    else if (c[6] && c[1] && !c[0]) mdl = 3'h1;
    else mdl = 3'h0;
  endfunction
  initial begin
    {power_save_en, pll_off_en, power_down, slow_osc_en, autoneg_en, link_up} = 6'h00;
    {soft_reset, tree_sw_en, long_pulse_gap, mii_variant, tree_strap_pin} = 5'h00;
    energy_detect_powerdown_disable = 1'b1;
    fault_dist_raw = 9'h000;
    rst = 1'b1;
    i = $urandom(32'h3715);
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(2);
    chk({power_state, low_power_mode}, 4'h0, "reset state");
    for (i = 0; i < 150; i++) begin
      v = $urandom;
      set(v);
      fault_dist_raw <= $urandom;
      cyc(2);
      s = mdl(v);
      chk(power_state, s, "state");
      chk(fault_dist, fault_dist_raw, "distance");
      if (s == 2) chk(pll_on, !v[4], "pll");
      if (s == 1) chk({rx_blocks_on, tx_on, energy_det_on, pll_on}, 4'h7, "save");
      if (s > 2) chk({mgmt_only, use_slow_osc, crystal_in_en}, {1'b1, s == 4, s != 4}, "pdown");
    end
    $display("mode table done");
    set(7'h02);
    for (g = 0; g < 2; g++) begin
      long_pulse_gap <= g;
      wp(t);
      wp(t);
      chk(t, g ? 40 : 20, "pulse gap");
    end
    set(7'h2E); cyc(2); chk(power_state, 3'h4, "slow");
    set(7'h2A); cyc(2); chk(power_state, 3'h3, "pdown");
    set(7'h62); cyc(2); chk(power_state, 3'h1, "save again");
    @(posedge clk_sys) soft_reset <= 1'b1;
    @(posedge clk_sys) soft_reset <= 1'b0;
    #1 chk(power_state, 3'h0, "soft reset");
    $display("exit sequence done");
    for (g = 0; g < 2; g++) begin
      board.all_high;
      mii_variant <= g;
      tree_sw_en <= 1'b1;
      cyc(5);
      chk({tree_active, pins_input_only, txd1_out}, 3'h7, "tree up");
      k = 0;
      for (i = 0; i < 11; i++) begin
        board.drop(i);
        if (!(g && i == 8)) k++;
        cyc(5);
        chk(txd1_out, !k[0], "tree out");
      end
    end
    tree_sw_en <= 1'b0;
    tree_strap_pin <= 1'b1;
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(6);
    chk(tree_active, 1'b1, "strap tree");
    $display("tree test done");
    close_out;
  end
endmodule // ppc_power_ctrl_tb_top
